// ===== pfs_pkg.sv
// Constants and types shared by the program flow sequencer and its tick generator.
// Assumes a single 40 MHz core clock and 32-bit instruction value fields.
package pfs_pkg;

  localparam int unsigned PFS_CLK_HZ = 40000000;
  localparam int unsigned PFS_TICK_MS = 10;
  localparam int unsigned PFS_TICK_CYCLES = PFS_CLK_HZ / 1000 * PFS_TICK_MS;
  localparam int unsigned PFS_TICK_CNT_W = 19;

  localparam int unsigned PFS_PC_W = 32;
  localparam int unsigned PFS_STACK_DEPTH = 8;
  localparam int unsigned PFS_SP_W = 4;
  localparam int unsigned PFS_MOTOR_CNT = 1;

  localparam logic [7:0] PFS_OP_COMPARE = 8'h14;
  localparam logic [7:0] PFS_OP_CONDITIONAL_JUMP = 8'h15;
  localparam logic [7:0] PFS_OP_JUMP_ALWAYS = 8'h16;
  localparam logic [7:0] PFS_OP_CALL_SUBROUTINE = 8'h17;
  localparam logic [7:0] PFS_OP_RETURN_SUBROUTINE = 8'h18;
  localparam logic [7:0] PFS_OP_WAIT = 8'h1B;

  localparam logic [7:0] PFS_WAIT_TICKS = 8'h00;
  localparam logic [7:0] PFS_WAIT_TARGET = 8'h01;
  localparam logic [7:0] PFS_WAIT_HOME = 8'h02;
  localparam logic [7:0] PFS_WAIT_END = 8'h03;

  localparam logic [7:0] PFS_CJ_ZERO = 8'h00;
  localparam logic [7:0] PFS_CJ_NOT_ZERO = 8'h01;
  localparam logic [7:0] PFS_CJ_EQUAL = 8'h02;
  localparam logic [7:0] PFS_CJ_NOT_EQUAL = 8'h03;
  localparam logic [7:0] PFS_CJ_GREATER = 8'h04;
  localparam logic [7:0] PFS_CJ_GREATER_EQ = 8'h05;
  localparam logic [7:0] PFS_CJ_LOWER = 8'h06;
  localparam logic [7:0] PFS_CJ_LOWER_EQ = 8'h07;
  localparam logic [7:0] PFS_CJ_TIMEOUT = 8'h08;
  localparam logic [7:0] PFS_CJ_ALARM = 8'h09;
  localparam logic [7:0] PFS_CJ_DEVIATION = 8'h0A;
  localparam logic [7:0] PFS_CJ_POSITION = 8'h0B;

  localparam logic [31:0] PFS_USE_ACCU = 32'hFFFFFFFF;
  localparam logic [31:0] PFS_ZERO32 = 32'h00000000;
  localparam logic [31:0] PFS_ONE32 = 32'h00000001;
  localparam logic [PFS_SP_W-1:0] PFS_SP_ONE = 4'h1;
  localparam logic [PFS_SP_W-1:0] PFS_SP_FULL = 4'h8;
  localparam logic [PFS_SP_W-1:0] PFS_SP_EMPTY = 4'h0;

  typedef enum logic [1:0] {
    PFS_ST_RUN = 2'b01,
    PFS_ST_WAIT = 2'b10
  } pfs_state_type;

endpackage

// ===== pfs_tick_gen.sv
// Tick generator for wait counting: one pulse every TICK_CYCLES core clocks.
// Assumes restart_i is a one-cycle pulse from the sequencer when a wait begins.
`timescale 1ns/1ps
module pfs_tick_gen
  import pfs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PFS_TICK_CYCLES
)
(
  input wire logic core_clk_i, // Core clock.
  input wire logic reset_i, // Asynchronous reset, active high.
  input wire logic ce_i, // Clock enable.
  input wire logic restart_i, // Restart the tick period.
  output logic tick_o // One-cycle tick pulse.
);

  logic [PFS_TICK_CNT_W-1:0] cnt_r;
  logic [PFS_TICK_CNT_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Restarting on wait entry makes the first tick a full period long.
  always_comb
  begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (restart_i)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r == PFS_TICK_CNT_W'(TICK_CYCLES - 1))
    begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
    else
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r & ce_i;

endmodule

// ===== pfs_sequencer.sv
// Program flow sequencer: jumps, subroutine calls, compare flags and waits.
// Assumes program memory presents the frame at pc_o and holds it until taken.
//
// Overview of operation
// - Jump always loads value into program counter.
// - Call pushes return address, then jumps.
// - Return stack holds at most eight entries.
// - Call with full stack just advances.
// - Return pops last saved address into counter.
// - Return with empty stack just advances.
// - Wait holds counter until condition or timeout.
// - Tick wait stalls for value ticks.
// - Target wait stalls until motor reaches position.
// - Home switch wait stalls until switch triggers.
// - End switch wait stalls until switch triggers.
// - Event waits use value as timeout, zero none.
// - Value minus one takes count from accumulator.
// - Timeout sets sticky flag, cleared by clear-error.
// - One tick lasts ten milliseconds.
// - Conditional jump loads counter when flags match.
// - Compare sets flags from accumulator minus value.
`timescale 1ns/1ps
module pfs_sequencer
  import pfs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PFS_TICK_CYCLES
)
(
  input wire logic core_clk_i, // Core clock, 40 MHz.
  input wire logic reset_i, // Asynchronous reset, active high.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input wire logic instr_valid_i, // Frame at pc_o is present.
  input wire logic [7:0] frame_addr_i, // Frame target address byte.
  input wire logic [7:0] frame_op_i, // Instruction number.
  input wire logic [7:0] frame_type_i, // Type field.
  input wire logic [7:0] frame_motor_i, // Motor or bank field.
  input wire logic [31:0] frame_value_i, // Value field.
  input wire logic [7:0] frame_sum_i, // Frame checksum byte.
  input wire logic [31:0] accumulator_i, // Accumulator contents.
  input wire logic [PFS_MOTOR_CNT-1:0] target_reached_i, // Target position reached.
  input wire logic [PFS_MOTOR_CNT-1:0] home_switch_i, // Reference switch level.
  input wire logic [PFS_MOTOR_CNT-1:0] end_switch_i, // Limit switch level.
  input wire logic ext_alarm_i, // External alarm condition.
  input wire logic deviation_err_i, // Deviation error condition.
  input wire logic position_err_i, // Position error condition.
  input wire logic clear_error_i, // Clear-error instruction executes.
  output logic instr_ready_o, // Frame is taken this cycle.
  output logic [PFS_PC_W-1:0] pc_o, // Program counter.
  output logic waiting_o, // A wait is in progress.
  output logic timeout_error_flag_o, // Sticky wait timeout flag.
  output logic checksum_error_o, // Bad frame dropped, one-cycle pulse.
  output logic [PFS_SP_W-1:0] stack_depth_o // Return stack entries in use.
);

  pfs_state_type state_r;
  pfs_state_type state_nxt;
  logic [PFS_PC_W-1:0] pc_r;
  logic [PFS_PC_W-1:0] pc_nxt;
  logic [PFS_PC_W-1:0] stack_r [PFS_STACK_DEPTH];
  logic [PFS_PC_W-1:0] push_val;
  logic push;
  logic [PFS_SP_W-1:0] sp_r;
  logic [PFS_SP_W-1:0] sp_nxt;
  logic [PFS_SP_W-1:0] sp_dec;
  logic [31:0] wait_cnt_r;
  logic [31:0] wait_cnt_nxt;
  logic [7:0] wait_type_r;
  logic [7:0] wait_type_nxt;
  logic [7:0] wait_motor_r;
  logic [7:0] wait_motor_nxt;
  logic timeout_en_r;
  logic timeout_en_nxt;
  logic zero_r;
  logic zero_nxt;
  logic less_r;
  logic less_nxt;
  logic eto_r;
  logic eto_nxt;
  logic sum_err_r;
  logic sum_err_nxt;
  logic tick;
  logic restart;
  logic taken;
  logic sum_ok;
  logic [7:0] sum;
  logic [31:0] wait_src;
  logic cond_met;
  logic cj_true;
  logic count_out;

  assign taken = instr_valid_i & ce_i & (state_r == PFS_ST_RUN);
  assign sp_dec = sp_r - PFS_SP_ONE;
  // Checksum over the eight leading frame bytes, modulo 256.
  assign sum = frame_addr_i + frame_op_i + frame_type_i + frame_motor_i + frame_value_i[31:24]
    + frame_value_i[23:16] + frame_value_i[15:8] + frame_value_i[7:0];
  assign sum_ok = (sum == frame_sum_i);
  // A negative accumulator is the program's fault and is not guarded here.
  assign wait_src = (frame_value_i == PFS_USE_ACCU) ? accumulator_i : frame_value_i;
  assign restart = taken & sum_ok & (frame_op_i == PFS_OP_WAIT);

  pfs_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .restart_i(restart),
    .tick_o(tick)
  );

  always_comb
  begin
    cond_met = 1'b0;
    if (wait_motor_r < 8'(PFS_MOTOR_CNT))
    begin
      unique case (wait_type_r)
        PFS_WAIT_TARGET: cond_met = target_reached_i[wait_motor_r[0]];
        PFS_WAIT_HOME: cond_met = home_switch_i[wait_motor_r[0]];
        PFS_WAIT_END: cond_met = end_switch_i[wait_motor_r[0]];
        default: cond_met = 1'b0;
      endcase
    end
  end

  // Flags from the last compare: zero means equal, less means signed below.
  always_comb
  begin
    unique case (frame_type_i)
      PFS_CJ_ZERO, PFS_CJ_EQUAL: cj_true = zero_r;
      PFS_CJ_NOT_ZERO, PFS_CJ_NOT_EQUAL: cj_true = ~zero_r;
      PFS_CJ_GREATER: cj_true = ~zero_r & ~less_r;
      PFS_CJ_GREATER_EQ: cj_true = ~less_r;
      PFS_CJ_LOWER: cj_true = less_r;
      PFS_CJ_LOWER_EQ: cj_true = less_r | zero_r;
      PFS_CJ_TIMEOUT: cj_true = eto_r;
      PFS_CJ_ALARM: cj_true = ext_alarm_i;
      PFS_CJ_DEVIATION: cj_true = deviation_err_i;
      PFS_CJ_POSITION: cj_true = position_err_i;
      default: cj_true = 1'b0;
    endcase
  end

  // Tick waits end on the count; event waits only with a timeout set.
  assign count_out = (wait_cnt_r == PFS_ZERO32) & ((wait_type_r == PFS_WAIT_TICKS) | timeout_en_r);

  always_comb
  begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    push = 1'b0;
    push_val = pc_r + PFS_ONE32;
    wait_cnt_nxt = wait_cnt_r;
    wait_type_nxt = wait_type_r;
    wait_motor_nxt = wait_motor_r;
    timeout_en_nxt = timeout_en_r;
    zero_nxt = zero_r;
    less_nxt = less_r;
    eto_nxt = eto_r;
    sum_err_nxt = 1'b0;
    if (clear_error_i)
    begin
      eto_nxt = 1'b0;
    end
    unique case (state_r)
      PFS_ST_RUN:
      begin
        if (taken & ~sum_ok)
        begin
          sum_err_nxt = 1'b1;
          pc_nxt = pc_r + PFS_ONE32;
        end
        else if (taken)
        begin
          pc_nxt = pc_r + PFS_ONE32;
          unique case (frame_op_i)
            PFS_OP_JUMP_ALWAYS: pc_nxt = frame_value_i;
            PFS_OP_CONDITIONAL_JUMP:
            begin
              if (cj_true)
              begin
                pc_nxt = frame_value_i;
              end
            end
            PFS_OP_COMPARE:
            begin
              zero_nxt = (accumulator_i == frame_value_i);
              less_nxt = ($signed(accumulator_i) < $signed(frame_value_i));
            end
            PFS_OP_CALL_SUBROUTINE:
            begin
              // A full stack ignores the call and falls through.
              if (sp_r != PFS_SP_FULL)
              begin
                push = 1'b1;
                sp_nxt = sp_r + PFS_SP_ONE;
                pc_nxt = frame_value_i;
              end
            end
            PFS_OP_RETURN_SUBROUTINE:
            begin
              if (sp_r != PFS_SP_EMPTY)
              begin
                sp_nxt = sp_r - PFS_SP_ONE;
                pc_nxt = stack_r[sp_dec[2:0]];
              end
            end
            PFS_OP_WAIT:
            begin
              if (frame_type_i <= PFS_WAIT_END)
              begin
                pc_nxt = pc_r;
                state_nxt = PFS_ST_WAIT;
                wait_cnt_nxt = wait_src;
                wait_type_nxt = frame_type_i;
                wait_motor_nxt = frame_motor_i;
                timeout_en_nxt = (wait_src != PFS_ZERO32);
              end
            end
            default: pc_nxt = pc_r + PFS_ONE32;
          endcase
        end
      end
      PFS_ST_WAIT:
      begin
        if ((wait_type_r != PFS_WAIT_TICKS) & cond_met)
        begin
          state_nxt = PFS_ST_RUN;
          pc_nxt = pc_r + PFS_ONE32;
        end
        else if (count_out)
        begin
          state_nxt = PFS_ST_RUN;
          pc_nxt = pc_r + PFS_ONE32;
          if (wait_type_r != PFS_WAIT_TICKS)
          begin
            eto_nxt = 1'b1;
          end
        end
        else if (tick & (wait_cnt_r != PFS_ZERO32))
        begin
          wait_cnt_nxt = wait_cnt_r - PFS_ONE32;
        end
      end
      default: state_nxt = PFS_ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= PFS_ST_RUN;
      pc_r <= '0;
      sp_r <= PFS_SP_EMPTY;
      wait_cnt_r <= '0;
      wait_type_r <= '0;
      wait_motor_r <= '0;
      timeout_en_r <= 1'b0;
      zero_r <= 1'b0;
      less_r <= 1'b0;
      eto_r <= 1'b0;
      sum_err_r <= 1'b0;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      wait_type_r <= wait_type_nxt;
      wait_motor_r <= wait_motor_nxt;
      timeout_en_r <= timeout_en_nxt;
      zero_r <= zero_nxt;
      less_r <= less_nxt;
      eto_r <= eto_nxt;
      sum_err_r <= sum_err_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < PFS_STACK_DEPTH; i++)
      begin
        stack_r[i] <= '0;
      end
    end
    else if (ce_i & push)
    begin
      stack_r[sp_r[2:0]] <= push_val;
    end
  end

  assign instr_ready_o = taken;
  assign pc_o = pc_r;
  assign waiting_o = (state_r == PFS_ST_WAIT);
  assign timeout_error_flag_o = eto_r;
  assign checksum_error_o = sum_err_r;
  assign stack_depth_o = sp_r;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // The extra condition is folded into the sequence, as a sequence is no boolean operand.
  sequence good_op_s(logic [7:0] op, logic cond);
    taken && sum_ok && (frame_op_i == op) && cond;
  endsequence

  jump_load_a: assert property (good_op_s(PFS_OP_JUMP_ALWAYS, 1'b1)
    |=> pc_o == $past(frame_value_i))
    else $error("jump did not load the program counter");
  call_push_a: assert property (good_op_s(PFS_OP_CALL_SUBROUTINE, sp_r != PFS_SP_FULL)
    |=> pc_o == $past(frame_value_i) && stack_depth_o == $past(stack_depth_o) + PFS_SP_ONE)
    else $error("call did not push and jump");
  stack_bound_a: assert property (stack_depth_o <= PFS_SP_FULL)
    else $error("return stack deeper than eight");
  full_call_a: assert property (good_op_s(PFS_OP_CALL_SUBROUTINE, sp_r == PFS_SP_FULL)
    |=> pc_o == $past(pc_o) + PFS_ONE32 && stack_depth_o == PFS_SP_FULL)
    else $error("call on full stack was not ignored");
  ret_pop_a: assert property (good_op_s(PFS_OP_CALL_SUBROUTINE, sp_r != PFS_SP_FULL)
    ##1 good_op_s(PFS_OP_RETURN_SUBROUTINE, 1'b1) |=> pc_o == $past(pc_o, 2) + PFS_ONE32)
    else $error("return did not restore the caller address");
  empty_ret_a: assert property (good_op_s(PFS_OP_RETURN_SUBROUTINE, sp_r == PFS_SP_EMPTY)
    |=> pc_o == $past(pc_o) + PFS_ONE32)
    else $error("return on empty stack was not ignored");
  wait_hold_a: assert property (waiting_o && $past(waiting_o) |-> $stable(pc_o))
    else $error("program counter moved during a wait");
  timeout_set_a: assert property (waiting_o && ce_i && count_out && !cond_met &&
    wait_type_r != PFS_WAIT_TICKS |=> timeout_error_flag_o && !waiting_o)
    else $error("timeout did not set the error flag");
  flag_hold_a: assert property (timeout_error_flag_o && !clear_error_i
    |=> timeout_error_flag_o)
    else $error("timeout flag dropped without a clear");
  cjump_eto_a: assert property (good_op_s(PFS_OP_CONDITIONAL_JUMP,
    frame_type_i == PFS_CJ_TIMEOUT && eto_r) |=> pc_o == $past(frame_value_i))
    else $error("conditional jump on timeout flag not taken");
  zero_tick_a: assert property (good_op_s(PFS_OP_WAIT, frame_type_i == PFS_WAIT_TICKS &&
    frame_value_i == PFS_ZERO32) ##1 ce_i |=> !waiting_o)
    else $error("zero tick wait did not end at once");

endmodule

// ===== pfs_prog_model.sv
// Behavioural program memory that presents one command frame at the program counter.
// Assumes the bench loads frames with clear and put before it raises en_i.
`timescale 1ns/1ps
module pfs_prog_model
  import pfs_pkg::*;
(
  input wire logic [PFS_PC_W-1:0] pc_i, // Program counter from the sequencer.
  input wire logic en_i, // Fetch enable from the bench.
  output logic valid_o, // Frame present.
  output logic [7:0] addr_o, // Target address byte.
  output logic [7:0] op_o, // Instruction number.
  output logic [7:0] type_o, // Type field.
  output logic [7:0] motor_o, // Motor field.
  output logic [31:0] value_o, // Value field.
  output logic [7:0] sum_o // Checksum byte.
);
  logic [7:0] m_op [64];
  logic [7:0] m_ty [64];
  logic [7:0] m_mo [64];
  logic [31:0] m_val [64];
  logic m_bad [64];
  logic [5:0] idx;
  logic [7:0] sum;

  assign idx = pc_i[5:0];

  task automatic clear();
    for (int i = 0; i < 64; i++)
    begin
      m_op[i] = 8'h00;
      m_ty[i] = 8'h00;
      m_mo[i] = 8'h00;
      m_val[i] = 32'h00000000;
      m_bad[i] = 1'b0;
    end
  endtask

  task automatic put(input int a, input logic [7:0] op, input logic [7:0] ty,
                     input logic [7:0] mo, input logic [31:0] val, input logic bad);
    m_op[a] = op;
    m_ty[a] = ty;
    m_mo[a] = mo;
    m_val[a] = val;
    m_bad[a] = bad;
  endtask

  // The checksum is the byte sum of the eight leading bytes; bad frames are off by one.
  always_comb
  begin
    sum = 8'h01 + m_op[idx] + m_ty[idx] + m_mo[idx] + m_val[idx][31:24] + m_val[idx][23:16]
      + m_val[idx][15:8] + m_val[idx][7:0] + {7'h00, m_bad[idx]};
  end

  // A released bus shows the inverse of the frame, so stale data can never pass.
  always_comb
  begin
    valid_o = en_i;
    addr_o = en_i ? 8'h01 : 8'hFE;
    op_o = en_i ? m_op[idx] : ~m_op[idx];
    type_o = en_i ? m_ty[idx] : ~m_ty[idx];
    motor_o = en_i ? m_mo[idx] : ~m_mo[idx];
    value_o = en_i ? m_val[idx] : ~m_val[idx];
    sum_o = en_i ? sum : ~sum;
  end
endmodule

// ===== program_flow_sequencer_tb_top.sv
// Self-checking bench for the program flow sequencer with a short tick period.
// Assumes the program model answers combinationally from the program counter.
`timescale 1ns/1ps
module program_flow_sequencer_tb_top;
  import pfs_pkg::*;
  localparam int TK = 4;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic [31:0] accu = 32'h00000000;
  logic tgt = 1'b0;
  logic home = 1'b0;
  logic ends = 1'b0;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic alarm = 1'b0;
  logic valid, rdy, waiting, tflag, serr;
  logic [7:0] fa, fo, ft, fm, fs;
  logic [31:0] fv, pc;
  logic [3:0] depth;
  int bad_count = 0;
  int n_checks = 0;

  always #12.5 core_clk = ~core_clk;

  pfs_prog_model MEM (.pc_i(pc), .en_i(run), .valid_o(valid), .addr_o(fa), .op_o(fo),
    .type_o(ft), .motor_o(fm), .value_o(fv), .sum_o(fs));

  pfs_sequencer #(.TICK_CYCLES(TK)) DUT (.core_clk_i(core_clk), .reset_i(reset), .ce_i(ce),
    .instr_valid_i(valid), .frame_addr_i(fa), .frame_op_i(fo), .frame_type_i(ft),
    .frame_motor_i(fm), .frame_value_i(fv), .frame_sum_i(fs), .accumulator_i(accu),
    .target_reached_i(tgt), .home_switch_i(home), .end_switch_i(ends), .ext_alarm_i(alarm),
    .deviation_err_i(1'b0), .position_err_i(1'b0), .clear_error_i(clr),
    .instr_ready_o(rdy), .pc_o(pc), .waiting_o(waiting), .timeout_error_flag_o(tflag),
    .checksum_error_o(serr), .stack_depth_o(depth));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic restart();
    @(posedge core_clk);
    reset <= 1'b1;
    run <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    MEM.clear();
  endtask

  // Lets exactly n frames be taken, then samples after the last edge has settled.
  task automatic go(input int n);
    @(posedge core_clk);
    run <= 1'b1;
    repeat (n) @(posedge core_clk);
    run <= 1'b0;
    #1;
  endtask

  task automatic wait_done(output int cnt);
    cnt = 0;
    while (waiting === 1'b1)
    begin
      @(posedge core_clk);
      #1;
      cnt++;
      if (cnt > 400)
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: wait never ended", $time);
        end_of_test();
      end
    end
  endtask

  task automatic t_jump();
    restart();
    MEM.put(0, PFS_OP_JUMP_ALWAYS, 8'h5A, 8'h03, 32'h0000000A, 1'b0);
    @(posedge core_clk);
    run <= 1'b1;
    #1;
    check({31'h0, rdy}, 32'h00000001, "frame offered is taken");
    @(posedge core_clk);
    run <= 1'b0;
    #1;
    check(pc, 32'h0000000A, "jump target");
  endtask

  task automatic t_call_ret();
    restart();
    MEM.put(0, PFS_OP_CALL_SUBROUTINE, 8'h00, 8'h00, 32'h00000014, 1'b0);
    MEM.put(20, PFS_OP_RETURN_SUBROUTINE, 8'h07, 8'h02, 32'h00000033, 1'b0);
    go(1);
    check(pc, 32'h00000014, "call target");
    check({28'h0, depth}, 32'h00000001, "depth after call");
    go(1);
    check(pc, 32'h00000001, "return address");
    check({28'h0, depth}, 32'h00000000, "depth after return");
    // A return right behind its call must still find the pushed address.
    MEM.put(1, PFS_OP_CALL_SUBROUTINE, 8'h00, 8'h00, 32'h0000001E, 1'b0);
    MEM.put(30, PFS_OP_RETURN_SUBROUTINE, 8'h00, 8'h00, 32'h00000000, 1'b0);
    go(2);
    check(pc, 32'h00000002, "back to back return");
    check({28'h0, depth}, 32'h00000000, "depth after quick return");
  endtask

  task automatic t_stack();
    restart();
    MEM.put(0, PFS_OP_RETURN_SUBROUTINE, 8'h00, 8'h00, 32'h00000000, 1'b0);
    for (int i = 1; i <= 9; i++)
      MEM.put(i, PFS_OP_CALL_SUBROUTINE, 8'h00, 8'h00, i + 1, 1'b0);
    go(1);
    check(pc, 32'h00000001, "return on empty stack");
    go(9);
    check({28'h0, depth}, 32'h00000008, "full stack depth");
    check(pc, 32'h0000000A, "call on full stack");
  endtask

  task automatic t_ticks(input int n, input logic use_acc);
    int cnt;
    logic len_ok;
    restart();
    accu <= n; // Accumulator is kept non-negative for this wait.
    MEM.put(0, PFS_OP_WAIT, PFS_WAIT_TICKS, 8'h09, use_acc ? PFS_USE_ACCU : n, 1'b0);
    go(1);
    check({31'h0, waiting}, 32'h00000001, "wait entered");
    wait_done(cnt);
    len_ok = cnt >= n * TK && cnt <= n * TK + 2;
    check({31'h0, len_ok}, 32'h00000001, "tick length");
    check(pc, 32'h00000001, "pc after tick wait");
    check({31'h0, tflag}, 32'h00000000, "no timeout on tick wait");
  endtask

  task automatic t_event(input logic [7:0] ty);
    int cnt;
    restart();
    MEM.put(0, PFS_OP_WAIT, ty, 8'h00, 32'h00000000, 1'b0);
    go(1);
    repeat (20) @(posedge core_clk);
    #1;
    check({31'h0, waiting}, 32'h00000001, "untimed wait still held");
    check(pc, 32'h00000000, "pc held in wait");
    @(posedge core_clk);
    run <= 1'b1;
    #1;
    check({31'h0, rdy}, 32'h00000000, "frame refused in wait");
    @(posedge core_clk);
    run <= 1'b0;
    tgt <= (ty == PFS_WAIT_TARGET);
    home <= (ty == PFS_WAIT_HOME);
    ends <= (ty == PFS_WAIT_END);
    #1;
    wait_done(cnt);
    check(cnt <= 3, 32'h00000001, "event ends wait");
    check(pc, 32'h00000001, "pc after event");
    check({31'h0, tflag}, 32'h00000000, "no flag on event");
    @(posedge core_clk);
    tgt <= 1'b0;
    home <= 1'b0;
    ends <= 1'b0;
  endtask

  task automatic t_timeout();
    int cnt;
    restart();
    MEM.put(0, PFS_OP_WAIT, PFS_WAIT_TARGET, 8'h00, 32'h00000002, 1'b0);
    go(1);
    wait_done(cnt);
    check(cnt >= 2 * TK && cnt <= 2 * TK + 2, 32'h00000001, "timeout length");
    check({31'h0, tflag}, 32'h00000001, "timeout flag set");
    repeat (5) @(posedge core_clk);
    #1;
    check({31'h0, tflag}, 32'h00000001, "timeout flag sticky");
    MEM.put(1, PFS_OP_CONDITIONAL_JUMP, PFS_CJ_TIMEOUT, 8'h00, 32'h00000030, 1'b0);
    go(1);
    check(pc, 32'h00000030, "jump on timeout flag");
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    #1;
    check({31'h0, tflag}, 32'h00000000, "timeout flag cleared");
  endtask

  task automatic t_cond(input logic [7:0] cond, input logic [31:0] exp_pc);
    restart();
    accu <= 32'h00000005;
    alarm <= (cond == PFS_CJ_ALARM);
    MEM.put(0, PFS_OP_COMPARE, 8'h00, 8'h00, 32'h00000005, 1'b0);
    MEM.put(1, PFS_OP_CONDITIONAL_JUMP, cond, 8'h00, 32'h00000028, 1'b0);
    go(2);
    check(pc, exp_pc, "conditional jump");
  endtask

  // With the clock enable low the wait must neither count nor end.
  task automatic t_freeze();
    int cnt;
    restart();
    MEM.put(0, PFS_OP_WAIT, PFS_WAIT_TICKS, 8'h00, 32'h00000001, 1'b0);
    go(1);
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    check({31'h0, waiting}, 32'h00000001, "frozen wait held");
    check(pc, 32'h00000000, "frozen pc held");
    @(posedge core_clk);
    ce <= 1'b1;
    #1;
    wait_done(cnt);
    check(cnt <= TK + 2, 32'h00000001, "wait resumes after freeze");
    check(pc, 32'h00000001, "pc after frozen wait");
  endtask

  task automatic t_bad_sum();
    restart();
    MEM.put(0, PFS_OP_JUMP_ALWAYS, 8'h00, 8'h00, 32'h0000001E, 1'b1);
    go(1);
    check(pc, 32'h00000001, "bad frame skipped");
    check({31'h0, serr}, 32'h00000001, "checksum error pulse");
  endtask

  initial
  begin
    MEM.clear();
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_jump();
    t_call_ret();
    t_stack();
    t_ticks(3, 1'b0);
    t_ticks(0, 1'b0);
    t_ticks(2, 1'b1);
    t_freeze();
    t_event(PFS_WAIT_TARGET);
    t_event(PFS_WAIT_HOME);
    t_event(PFS_WAIT_END);
    t_timeout();
    t_cond(PFS_CJ_EQUAL, 32'h00000028);
    t_cond(PFS_CJ_NOT_EQUAL, 32'h00000002);
    t_cond(PFS_CJ_GREATER, 32'h00000002);
    t_cond(PFS_CJ_GREATER_EQ, 32'h00000028);
    t_cond(PFS_CJ_LOWER, 32'h00000002);
    t_cond(PFS_CJ_LOWER_EQ, 32'h00000028);
    t_cond(PFS_CJ_ALARM, 32'h00000028);
    t_cond(PFS_CJ_DEVIATION, 32'h00000002);
    t_bad_sum();
    end_of_test();
  end
endmodule
